// *** core/mac_timer_regs.svh ***
`ifndef MAC_TIMER_REGS_SVH
`define MAC_TIMER_REGS_SVH

// special function register offsets
`define MT_ADDR_CFG 8'hc3
`define MT_ADDR_THI 8'ha7
`define MT_ADDR_TLO 8'ha6

// configuration field positions
`define MT_CFG_CMPF 7
`define MT_CFG_OVFF 6
`define MT_CFG_OFCF 5
`define MT_CFG_UNUSED 4
`define MT_CFG_SRCSEL 3
`define MT_CFG_RSVD 2
`define MT_CFG_ALIGN 1
`define MT_CFG_RUN 0

// reset values
`define MT_CFG_RST 8'h02
`define MT_THI_RST 8'h00

// cycles from sampled slow-clock edge to run state
`define MT_ALIGN_START_CYC 75

`endif

// *** core/mac_timer_pkg.sv ***
package mac_timer_pkg;

   // timer control states
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_START_WAIT,
      ST_START_LOAD,
      ST_RUN,
      ST_STOP_WAIT
   } tmr_state_t;

   // one register access from the core
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } sfr_req_t;

   // one-cycle event pulses toward the rest of the timer
   typedef struct packed {
      logic compare;
      logic overflow;
      logic reload;
      logic sleep_store;
   } tmr_evt_t;

endpackage : mac_timer_pkg

// *** core/slow_edge_sync.sv ***
`timescale 1ns/1ps
`default_nettype none

module slow_edge_sync (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic ce,
   // asynchronous pin and its filtered forms
   input wire logic pin,
   output logic level,
   output logic rise
);

   logic [2:0] sh_r;
   logic [2:0] sh_nxt;
   logic lvl_r;
   logic lvl_nxt;
   logic rise_r;
   logic rise_nxt;

   // a change counts only once stages two and three agree
   always_comb begin
      sh_nxt = {sh_r[1:0], pin};
      lvl_nxt = lvl_r;
      if (sh_r[1] == sh_r[2]) begin
         lvl_nxt = sh_r[2];
      end
      rise_nxt = lvl_nxt & ~lvl_r;
   end

   // stage one feeds only stage two
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         sh_r <= 3'h0;
         lvl_r <= 1'b0;
         rise_r <= 1'b0;
      end else if (ce) begin
         sh_r <= sh_nxt;
         lvl_r <= lvl_nxt;
         rise_r <= rise_nxt;
      end
   end

   assign level = lvl_r;
   assign rise = rise_r;

endmodule : slow_edge_sync

`default_nettype wire

// *** core/mac_timer_ctrl.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "mac_timer_regs.svh"

// Overview of operation
// - compare event sets compare flag
// - timer reaching period sets overflow flag
// - overflow-count compare event sets its flag
// - flags set by hardware, cleared writing zero
// - bit 4 reads zero; software writes bit2 zero
// - select bit picks high or low byte
// - align off: start and stop immediate
// - align on: slow edge start/stop, reload
// - run write one starts, zero stops
// - run bit reads actual timer state
// - aligned status changes only after the edge
// - high byte reads value latched at low read
// - running high write loads delta, halts timer
// - idle high write loads timer high byte
// - delta counts down once, then timer resumes
// - running low write held until high write
// - aligned start takes 75 cycles from edge
// - compare when counting to value at least compare
module mac_timer_ctrl #(
   parameter int unsigned START_CYC = `MT_ALIGN_START_CYC
) (
   // clock, reset, enable
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic ce,
   // register access
   input wire mac_timer_pkg::sfr_req_t sfr_req,
   output logic [7:0] sfr_rdata,
   // slow clock pin
   input wire logic clk32k_pin,
   // from the rest of the timer
   input wire logic [15:0] period,
   input wire logic [7:0] cmp_value,
   input wire logic ovf_cmp_evt,
   input wire logic [15:0] reload_value,
   // to the rest of the timer
   output logic [15:0] timer_value,
   output mac_timer_pkg::tmr_evt_t evt
);

   localparam logic [6:0] LOAD_LAST = 7'(START_CYC - 1);
   localparam logic [7:0] CFG_RST = `MT_CFG_RST;

   mac_timer_pkg::tmr_state_t st_r, st_nxt;
   logic [6:0] cnt_r, cnt_nxt;
   logic [15:0] tmr_r, tmr_nxt;
   logic [15:0] dlt_r, dlt_nxt;
   logic [7:0] lo_hold_r, lo_hold_nxt;
   logic [7:0] hi_lat_r, hi_lat_nxt;
   logic [7:0] rdata_r, rdata_nxt;
   logic [2:0] flg_r, flg_nxt; // compare, overflow, count compare
   logic srcsel_r, srcsel_nxt;
   logic rsvd_r, rsvd_nxt;
   logic align_r, align_nxt;
   mac_timer_pkg::tmr_evt_t evt_r, evt_nxt;
   logic slow_rise;
   logic running, tick, cmp_hit, ovf_hit, wr_cfg, wr_thi, wr_tlo, rd_tlo;
   logic [15:0] tmr_inc;
   logic [7:0] cur_sel, nx_sel;
   logic [2:0] flg_set, flg_clr;

   // pick the compared byte of a timer value
   function automatic logic [7:0] sel_byte(input logic [15:0] v, input logic lo);
      sel_byte = lo ? v[7:0] : v[15:8];
   endfunction : sel_byte

   slow_edge_sync u_sync (
      .sys_clk(sys_clk),
      .rstn(rstn),
      .ce(ce),
      .pin(clk32k_pin),
      .level(),
      .rise(slow_rise)
   );

   // decode and counting terms
   assign wr_cfg = sfr_req.wr && sfr_req.addr == `MT_ADDR_CFG;
   assign wr_thi = sfr_req.wr && sfr_req.addr == `MT_ADDR_THI;
   assign wr_tlo = sfr_req.wr && sfr_req.addr == `MT_ADDR_TLO;
   assign rd_tlo = sfr_req.rd && sfr_req.addr == `MT_ADDR_TLO;
   assign running = st_r == mac_timer_pkg::ST_RUN || st_r == mac_timer_pkg::ST_STOP_WAIT;
   assign tick = running && dlt_r == 16'h0000;
   assign tmr_inc = tmr_r + 16'h0001;
   assign ovf_hit = tick && tmr_inc >= period;
   assign cur_sel = sel_byte(tmr_r, srcsel_r);
   assign nx_sel = sel_byte(tmr_inc, srcsel_r);
   // crossing up to or past compare, wrap included
   assign cmp_hit = tick && nx_sel >= cmp_value && (cur_sel < cmp_value || nx_sel < cur_sel);

   // flags: a set in the clearing cycle wins
   // only zero clears, hardware sets
   assign flg_clr = wr_cfg ? ~sfr_req.wdata[`MT_CFG_CMPF:`MT_CFG_OFCF] : 3'h0;
   assign flg_set = {cmp_hit, ovf_hit, ovf_cmp_evt};

   // next values of timer, state and registers
   always_comb begin
      st_nxt = st_r;
      cnt_nxt = cnt_r;
      tmr_nxt = tmr_r;
      dlt_nxt = dlt_r;
      lo_hold_nxt = lo_hold_r;
      hi_lat_nxt = hi_lat_r;
      rdata_nxt = rdata_r;
      srcsel_nxt = srcsel_r;
      rsvd_nxt = rsvd_r;
      align_nxt = align_r;
      evt_nxt = '0;
      flg_nxt = (flg_r & ~flg_clr) | flg_set;
      evt_nxt.compare = cmp_hit;
      evt_nxt.overflow = ovf_hit;
      // countdown at timer rate, stops at zero
      if (running && dlt_r != 16'h0000) begin
         dlt_nxt = dlt_r - 16'h0001;
      end
      if (tick) begin
         tmr_nxt = ovf_hit ? 16'h0000 : tmr_inc;
      end
      // aligned transitions on the slow edge and at the end of the start count
      unique case (st_r)
         mac_timer_pkg::ST_IDLE: ;
         mac_timer_pkg::ST_RUN: ;
         mac_timer_pkg::ST_START_WAIT: begin
            if (slow_rise) begin
               st_nxt = mac_timer_pkg::ST_START_LOAD;
               cnt_nxt = 7'h01;
            end
         end
         mac_timer_pkg::ST_START_LOAD: begin
            // run 75 cycles after the edge
            if (cnt_r == LOAD_LAST) begin
               st_nxt = mac_timer_pkg::ST_RUN;
               tmr_nxt = reload_value;
               evt_nxt.reload = 1'b1;
            end else begin
               cnt_nxt = cnt_r + 7'h01;
            end
         end
         mac_timer_pkg::ST_STOP_WAIT: begin
            if (slow_rise) begin
               st_nxt = mac_timer_pkg::ST_IDLE;
               evt_nxt.sleep_store = 1'b1;
            end
         end
      endcase
      // configuration write
      if (wr_cfg) begin
         srcsel_nxt = sfr_req.wdata[`MT_CFG_SRCSEL];
         // stored as written, software keeps it zero
         rsvd_nxt = sfr_req.wdata[`MT_CFG_RSVD];
         align_nxt = sfr_req.wdata[`MT_CFG_ALIGN];
         if (sfr_req.wdata[`MT_CFG_RUN]) begin
            if (!align_r) begin
               st_nxt = mac_timer_pkg::ST_RUN;
            end else if (st_r == mac_timer_pkg::ST_IDLE) begin
               st_nxt = mac_timer_pkg::ST_START_WAIT;
            end else if (st_r == mac_timer_pkg::ST_STOP_WAIT) begin
               st_nxt = mac_timer_pkg::ST_RUN;
            end
         end else begin
            // aligned stop waits for the edge
            if (align_r && running) begin
               st_nxt = mac_timer_pkg::ST_STOP_WAIT;
            end else begin
               st_nxt = mac_timer_pkg::ST_IDLE;
            end
         end
      end
      // running high write starts a delta halt
      if (wr_thi) begin
         if (running) begin
            dlt_nxt = {sfr_req.wdata, lo_hold_r};
         end else begin
            tmr_nxt[15:8] = sfr_req.wdata;
         end
      end
      if (wr_tlo) begin
         if (running) begin
            lo_hold_nxt = sfr_req.wdata;
         end else begin
            tmr_nxt[7:0] = sfr_req.wdata;
         end
      end
      // read data, registered for the next cycle
      if (sfr_req.rd) begin
         unique case (sfr_req.addr)
            // run shows state, bit 4 zero
            `MT_ADDR_CFG: rdata_nxt = {flg_r, 1'b0, srcsel_r, rsvd_r, align_r, running};
            `MT_ADDR_THI: rdata_nxt = hi_lat_r;
            `MT_ADDR_TLO: rdata_nxt = tmr_r[7:0];
            default: rdata_nxt = 8'h00;
         endcase
      end
      // high byte caught when the low byte is read
      if (rd_tlo) begin
         hi_lat_nxt = tmr_r[15:8];
      end
   end

   // state registers, frozen while ce is low
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         st_r <= mac_timer_pkg::ST_IDLE;
         cnt_r <= 7'h00;
         tmr_r <= 16'h0000;
         dlt_r <= 16'h0000;
         lo_hold_r <= 8'h00;
         hi_lat_r <= `MT_THI_RST;
         flg_r <= 3'h0;
         srcsel_r <= CFG_RST[`MT_CFG_SRCSEL];
         rsvd_r <= CFG_RST[`MT_CFG_RSVD];
         align_r <= CFG_RST[`MT_CFG_ALIGN];
         rdata_r <= 8'h00;
         evt_r <= '0;
      end else if (ce) begin
         st_r <= st_nxt;
         cnt_r <= cnt_nxt;
         tmr_r <= tmr_nxt;
         dlt_r <= dlt_nxt;
         lo_hold_r <= lo_hold_nxt;
         hi_lat_r <= hi_lat_nxt;
         flg_r <= flg_nxt;
         srcsel_r <= srcsel_nxt;
         rsvd_r <= rsvd_nxt;
         align_r <= align_nxt;
         rdata_r <= rdata_nxt;
         evt_r <= evt_nxt;
      end
   end

   assign sfr_rdata = rdata_r;
   assign timer_value = tmr_r;
   assign evt = evt_r;

   // checks on flags, state and the value path
   AST_CMP_FLAG: assert property (@(posedge sys_clk) disable iff (!rstn)
      ce && cmp_hit |=> flg_r[2]) else $error("compare flag not set");
   AST_OVF_FLAG: assert property (@(posedge sys_clk) disable iff (!rstn)
      ce && ovf_hit |=> flg_r[1] && tmr_r == 16'h0000) else $error("overflow not taken");
   AST_OFC_FLAG: assert property (@(posedge sys_clk) disable iff (!rstn)
      ce && ovf_cmp_evt |=> flg_r[0]) else $error("count compare flag not set");
   AST_W1_KEEPS: assert property (@(posedge sys_clk) disable iff (!rstn)
      ce && wr_cfg && sfr_req.wdata[`MT_CFG_CMPF] && flg_r[2] |=> flg_r[2])
      else $error("writing one changed a flag");
   AST_BIT4_ZERO: assert property (@(posedge sys_clk) disable iff (!rstn)
      ce && sfr_req.rd && sfr_req.addr == `MT_ADDR_CFG |=> !sfr_rdata[`MT_CFG_UNUSED])
      else $error("unused bit read as one");
   AST_IMM_START: assert property (@(posedge sys_clk) disable iff (!rstn)
      ce && wr_cfg && sfr_req.wdata[`MT_CFG_RUN] && !align_r |=> st_r == mac_timer_pkg::ST_RUN)
      else $error("immediate start missed");
   AST_ALIGN_HOLD: assert property (@(posedge sys_clk) disable iff (!rstn)
      ce && st_r == mac_timer_pkg::ST_START_WAIT && !slow_rise && !wr_cfg
      |=> st_r == mac_timer_pkg::ST_START_WAIT) else $error("aligned start left early");
   AST_START_CNT: assert property (@(posedge sys_clk) disable iff (!rstn)
      ce && st_r == mac_timer_pkg::ST_START_LOAD && st_nxt == mac_timer_pkg::ST_RUN
      |-> cnt_r == LOAD_LAST ##1 evt_r.reload) else $error("aligned start count wrong");
   AST_HI_LATCH: assert property (@(posedge sys_clk) disable iff (!rstn)
      ce && rd_tlo |=> hi_lat_r == $past(tmr_r[15:8])) else $error("high byte not latched");
   AST_DELTA_HALT: assert property (@(posedge sys_clk) disable iff (!rstn)
      ce && running && dlt_r != 16'h0000 && !sfr_req.wr && st_nxt == st_r
      |=> $stable(tmr_r) && dlt_r == $past(dlt_r) - 16'h0001) else $error("delta halt broken");

   COV_ALIGNED_RUN: cover property (@(posedge sys_clk) disable iff (!rstn)
      st_r == mac_timer_pkg::ST_START_LOAD ##1 st_r == mac_timer_pkg::ST_RUN);
   COV_DELTA_DONE: cover property (@(posedge sys_clk) disable iff (!rstn)
      dlt_r == 16'h0001 ##1 dlt_r == 16'h0000);
   COV_CMP: cover property (@(posedge sys_clk) disable iff (!rstn) ce && cmp_hit);

endmodule : mac_timer_ctrl

`default_nettype wire

// *** test/tb_mac_timer_control_and_value.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "mac_timer_regs.svh"

module tb_mac_timer_control_and_value;
   // aligned start shortened to keep the run brief
   localparam int unsigned START_CYC = 10;
   logic sys_clk = 1'b0;
   logic rstn = 1'b0;
   logic ce = 1'b1;
   mac_timer_pkg::sfr_req_t sfr_req = '0;
   logic [7:0] sfr_rdata;
   logic clk32k_pin = 1'b0;
   logic [15:0] period = 16'hffff;
   logic [7:0] cmp_value = 8'h20;
   logic ovf_cmp_evt = 1'b0;
   logic [15:0] reload_value = 16'h0abc;
   logic [15:0] timer_value;
   mac_timer_pkg::tmr_evt_t evt;
   int n_errors = 0;
   int comparisons = 0;
   int cycles = 0;
   int n;
   logic [7:0] d;
   logic [15:0] t0;

   mac_timer_ctrl #(.START_CYC(START_CYC)) u_dut (
      .sys_clk(sys_clk), .rstn(rstn), .ce(ce), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
      .clk32k_pin(clk32k_pin), .period(period), .cmp_value(cmp_value),
      .ovf_cmp_evt(ovf_cmp_evt), .reload_value(reload_value),
      .timer_value(timer_value), .evt(evt));

   // 200 MHz system clock
   always #2.5 sys_clk = ~sys_clk;

   // hang guard, well above the expected few hundred cycles
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles >= 20000) begin
         n_errors++;
         wrap_up();
      end
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
      comparisons++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
      end
   endtask : chk

   // one write strobe, then an idle cycle before the next access
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge sys_clk);
      sfr_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
      @(posedge sys_clk);
      sfr_req.wr <= 1'b0;
   endtask : wr

   // data is registered at the taking edge and held, so sample one edge later
   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(posedge sys_clk);
      sfr_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(posedge sys_clk);
      sfr_req.rd <= 1'b0;
      @(posedge sys_clk);
      #1;
      v = sfr_rdata;
   endtask : rd

   // bounded wait for one event pulse: 3 compare, 2 overflow, 1 reload, 0 stored
   task automatic wait_evt(input int sel, input int lim, output int cnt);
      for (cnt = 1; cnt <= lim; cnt++) begin
         @(posedge sys_clk);
         #1;
         if (evt[sel] === 1'b1) break;
      end
      chk(16'(evt[sel]), 16'h0001, "event pulse missing");
   endtask : wait_evt

   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : wrap_up

   initial begin
      repeat (4) @(posedge sys_clk);
      rstn <= 1'b1;
      // reset values
      rd(`MT_ADDR_CFG, d);
      chk(16'(d), 16'h0002, "config reset");
      rd(`MT_ADDR_THI, d);
      chk(16'(d), 16'h0000, "high byte reset");
      $display("test reset done");
      // idle loads, immediate start, latched high read
      wr(`MT_ADDR_CFG, 8'h00);
      wr(`MT_ADDR_TLO, 8'hf0);
      wr(`MT_ADDR_THI, 8'h12);
      // timer register moves on the taking edge, so look just after it
      #1;
      chk(timer_value, 16'h12f0, "idle byte loads");
      rd(`MT_ADDR_TLO, d);
      chk(16'(d), 16'h00f0, "idle low byte read");
      wr(`MT_ADDR_CFG, 8'h01);
      rd(`MT_ADDR_CFG, d);
      chk(16'(d[`MT_CFG_RUN]), 16'h0001, "immediate start");
      rd(`MT_ADDR_TLO, d);
      repeat (40) @(posedge sys_clk);
      rd(`MT_ADDR_THI, d);
      chk(16'(d), 16'h0012, "latched high byte");
      $display("test start and latch done");
      // delta of 16 cycles from held low byte, then the timer resumes
      wr(`MT_ADDR_TLO, 8'h10);
      wr(`MT_ADDR_THI, 8'h00);
      #1;
      t0 = timer_value;
      repeat (8) @(posedge sys_clk);
      #1;
      chk(timer_value, t0, "timer held by delta");
      repeat (8) @(posedge sys_clk);
      #1;
      chk(timer_value, t0, "timer held to delta end");
      @(posedge sys_clk);
      #1;
      chk(timer_value, t0 + 16'h0001, "timer resumed");
      $display("test delta done");
      // event flags, compare on low byte
      wr(`MT_ADDR_CFG, 8'h00);
      period <= 16'h0040;
      wr(`MT_ADDR_TLO, 8'h00);
      wr(`MT_ADDR_THI, 8'h00);
      wr(`MT_ADDR_CFG, 8'h09);
      wait_evt(3, 100, n);
      wait_evt(2, 100, n);
      @(posedge sys_clk);
      ovf_cmp_evt <= 1'b1;
      @(posedge sys_clk);
      ovf_cmp_evt <= 1'b0;
      wr(`MT_ADDR_CFG, 8'he8);
      rd(`MT_ADDR_CFG, d);
      chk(16'(d), 16'h00e8, "flags set, ones kept");
      wr(`MT_ADDR_CFG, 8'h00);
      rd(`MT_ADDR_CFG, d);
      chk(16'(d), 16'h0000, "flags cleared by zero");
      // high byte never reaches the compare value
      wr(`MT_ADDR_CFG, 8'h01);
      repeat (150) @(posedge sys_clk);
      wr(`MT_ADDR_CFG, 8'hc0);
      rd(`MT_ADDR_CFG, d);
      chk(16'(d), 16'h0040, "no compare on high byte");
      $display("test flags done");
      // aligned start and stop; align must already be on when run is written
      @(posedge sys_clk);
      period <= 16'hffff;
      wr(`MT_ADDR_CFG, 8'h02);
      wr(`MT_ADDR_CFG, 8'h03);
      rd(`MT_ADDR_CFG, d);
      chk(16'(d), 16'h0002, "run waits for edge");
      @(posedge sys_clk);
      clk32k_pin <= 1'b1;
      wait_evt(1, 200, n);
      // three sync stages and the rise flag, then the start count
      chk(16'(n == START_CYC + 4), 16'h0001, "start latency");
      chk(timer_value, 16'h0abc, "reloaded timer");
      rd(`MT_ADDR_CFG, d);
      chk(16'(d), 16'h0003, "running after edge");
      wr(`MT_ADDR_CFG, 8'h02);
      rd(`MT_ADDR_CFG, d);
      chk(16'(d), 16'h0003, "stop waits for edge");
      @(posedge sys_clk);
      clk32k_pin <= 1'b0;
      repeat (10) @(posedge sys_clk);
      clk32k_pin <= 1'b1;
      wait_evt(0, 50, n);
      rd(`MT_ADDR_CFG, d);
      chk(16'(d), 16'h0002, "stopped after edge");
      $display("test aligned done");
      wrap_up();
   end
endmodule : tb_mac_timer_control_and_value

`default_nettype wire
